// ==== shared/ita_pkg.sv ====
package ita_pkg;
  // Register byte addresses
  localparam logic [15:0] ITA_ADDR_SUB_OUT_SEL = 16'hFF92;
  localparam logic [15:0] ITA_ADDR_TIMER_MODE  = 16'hFFB0;
  localparam logic [15:0] ITA_ADDR_TIMER_COUNT = 16'hFFB1;
  localparam logic [15:0] ITA_ADDR_CLOCK_STOP  = 16'hFFFA;
  // Reset values
  localparam logic [7:0] ITA_RST_SUB_OUT_SEL = 8'hFE;
  localparam logic [7:0] ITA_RST_TIMER_MODE  = 8'h10;
  localparam logic [7:0] ITA_RST_TIMER_COUNT = 8'h00;
  localparam logic [7:0] ITA_RST_CLOCK_STOP  = 8'hFF;
  localparam logic [7:0] ITA_UNMAPPED_READ   = 8'h00;
  // Reserved bits of the subclock output select register read as one
  localparam logic [6:0] ITA_SUB_OUT_RSVD    = 7'h7F;
  // Field positions
  localparam int ITA_OUT_SEL_MSB  = 7;
  localparam int ITA_OUT_SEL_LSB  = 5;
  localparam int ITA_FIXED_BIT    = 4;
  localparam int ITA_TBASE_BIT    = 3;
  localparam int ITA_CLEAR_BIT    = 2;
  localparam int ITA_STANDBY_BIT  = 0;
  localparam int ITA_DIRECT_BIT   = 0;
  // Prescaler widths
  localparam int ITA_SYS_W = 13;
  localparam int ITA_SUB_W = 7;
  // Interval taps as log2 of the divider, index = count select low bits
  localparam logic [3:0] ITA_SYS_TAP [8] = '{4'hD, 4'hC, 4'hB, 4'h9,
                                             4'h8, 4'h7, 4'h5, 4'h3};
  // Time-base taps (1 s, 0.5 s, 0.25 s, 31.25 ms at a 128 Hz subclock)
  localparam logic [2:0] ITA_SUB_TAP [4] = '{3'h7, 3'h6, 3'h5, 3'h2};
  // Divided output bit for /32, /16, /8, /4
  localparam logic [2:0] ITA_OUT_BIT [4] = '{3'h4, 3'h3, 3'h2, 3'h1};
  // Operating mode codes
  localparam logic [1:0] ITA_MODE_ACTIVE    = 2'h0;
  localparam logic [1:0] ITA_MODE_SLEEP     = 2'h1;
  localparam logic [1:0] ITA_MODE_SUBACTIVE = 2'h2;
  localparam logic [1:0] ITA_MODE_LOWPOWER  = 2'h3;
endpackage

// ==== core/ita_timer.sv ====
// The implementer's own choice: the address-and-strobe port.
module ita_timer
  import ita_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  input  wire logic              sub_clk,
  input  wire logic [1:0]        op_mode,
  input  wire logic              port_mode_one_oe,
  output logic                   clock_output_pin,
  output logic                   clock_output_pin_oe,
  output logic                   overflow_request,
  output logic [7:0]             timer_count
);

  // Register state
  logic [7:0]           timer_mode_q;
  logic [7:0]           timer_count_q;
  logic [7:0]           timer_count_d;
  logic [7:0]           clock_stop_q;
  logic                 direct_sub_q;
  logic [7:0]           timer_mode_d;
  logic [7:0]           clock_stop_d;
  logic                 direct_sub_d;
  logic [7:0]           rdata_q;
  logic [7:0]           rdata_d;
  logic [ITA_SYS_W-1:0] sys_pre_q;
  logic [ITA_SYS_W-1:0] sys_pre_d;
  logic [ITA_SUB_W-1:0] sub_pre_q;
  logic [ITA_SUB_W-1:0] sub_pre_d;
  logic                 sub_prev_q;
  logic                 sub_prev_d;
  logic                 pin_q;
  logic                 pin_d;
  logic                 pin_oe_q;
  logic                 pin_oe_d;
  logic                 ovf_q;
  logic                 ovf_d;

  // Address decode
  wire sel_mode  = (addr == ADDR_W'(ITA_ADDR_TIMER_MODE));
  wire sel_count = (addr == ADDR_W'(ITA_ADDR_TIMER_COUNT));
  wire sel_stop  = (addr == ADDR_W'(ITA_ADDR_CLOCK_STOP));
  wire sel_sub   = (addr == ADDR_W'(ITA_ADDR_SUB_OUT_SEL));

  // Mode fields
  wire       tbase_mode = timer_mode_q[ITA_TBASE_BIT];
  wire       hold_clear = tbase_mode & timer_mode_q[ITA_CLEAR_BIT];
  wire       standby    = ~clock_stop_q[ITA_STANDBY_BIT];
  wire [2:0] out_sel    = timer_mode_q[ITA_OUT_SEL_MSB:ITA_OUT_SEL_LSB];

  // Interval tick: low tap bits of the system prescaler all ones
  wire [3:0]           sys_tap  = ITA_SYS_TAP[timer_mode_q[2:0]];
  wire [ITA_SYS_W-1:0] sys_mask = ~({ITA_SYS_W{1'b1}} << sys_tap);
  wire                 sys_tick = &(sys_pre_q | ~sys_mask);

  // Time-base tick: subclock edge that carries the chosen tap over
  wire                 sub_rise = sub_clk & ~sub_prev_q;
  wire [2:0]           sub_tap  = ITA_SUB_TAP[timer_mode_q[1:0]];
  wire [ITA_SUB_W-1:0] sub_mask = ~({ITA_SUB_W{1'b1}} << sub_tap);
  wire                 sub_tick = sub_rise & (&(sub_pre_q | ~sub_mask));

  // Count enable; standby and hold stop counting
  wire count_tick = tbase_mode ? sub_tick : sys_tick;
  wire count_inc  = count_tick & ~standby & ~hold_clear;
  wire overflow   = count_inc & (timer_count_q == 8'hFF);

  // Counter next value
  always_comb begin
    timer_count_d = timer_count_q;
    if (hold_clear) begin
      timer_count_d = ITA_RST_TIMER_COUNT;
    end else if (count_inc) begin
      timer_count_d = timer_count_q + 8'h01;
    end
  end

  // Subclock prescaler next value
  always_comb begin
    sub_pre_d = sub_pre_q;
    if (hold_clear) begin
      sub_pre_d = '0;
    end else if (sub_rise) begin
      sub_pre_d = sub_pre_q + ITA_SUB_W'(1);
    end
  end

  // Mode permissions for the clock output
  wire sys_out_ok = (op_mode == ITA_MODE_ACTIVE) |
                    (op_mode == ITA_MODE_SLEEP);
  wire sub_out_ok = sys_out_ok |
                    (op_mode == ITA_MODE_SUBACTIVE);

  // Divided clock candidates
  wire sys_div = sys_pre_q[ITA_OUT_BIT[out_sel[1:0]]];
  wire sub_div = sub_pre_q[ITA_OUT_BIT[out_sel[1:0]]];

  // Output clock select
  always_comb begin
    if (direct_sub_q) begin
      pin_d = sub_prev_q;
    end else if (out_sel[2]) begin
      pin_d = sub_div & sub_out_ok;
    end else begin
      pin_d = sys_div & sys_out_ok;
    end
    if (!port_mode_one_oe) begin
      pin_d = 1'b0;
    end
  end

  // Read data mux
  wire [7:0] rd_mux = sel_mode  ? timer_mode_q :
                      sel_count ? timer_count_q :
                      sel_stop  ? clock_stop_q :
                      sel_sub   ? {ITA_SUB_OUT_RSVD, direct_sub_q} :
                      ITA_UNMAPPED_READ;

  // Write enables per register
  // Writes to the counter address or unmapped addresses fall through
  wire wr_mode = wr & sel_mode;
  wire wr_stop = wr & sel_stop;
  wire wr_sub  = wr & sel_sub;

  // Timer mode next value, fixed bit forced to one
  always_comb begin
    timer_mode_d = timer_mode_q;
    if (wr_mode) begin
      timer_mode_d = {wdata[7:5], 1'b1, wdata[3:0]};
    end
  end

  // Module stop register next value
  always_comb begin
    clock_stop_d = clock_stop_q;
    if (wr_stop) begin
      clock_stop_d = wdata;
    end
  end

  // Direct subclock select next value, reserved bits not stored
  always_comb begin
    direct_sub_d = direct_sub_q;
    if (wr_sub) begin
      direct_sub_d = wdata[ITA_DIRECT_BIT];
    end
  end

  // Read data stands in each cycle after a cycle with the strobe high, zero otherwise
  assign rdata_d = rd ? rd_mux : ITA_UNMAPPED_READ;

  // System prescaler runs free; standby does not stop it
  // Keeping it running keeps the system-derived pin clock alive
  assign sys_pre_d = sys_pre_q + ITA_SYS_W'(1);

  // Subclock sample for edge detection and the raw pin path
  // Reset value is low, so a low idle subclock gives no false edge
  assign sub_prev_d = sub_clk;

  // Overflow pulse and pin enable copies
  assign ovf_d    = overflow;
  assign pin_oe_d = port_mode_one_oe;

  // Timer mode register
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_mode_q <= ITA_RST_TIMER_MODE;
    end else begin
      timer_mode_q <= timer_mode_d;
    end
  end

  // Module stop register
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_stop_q <= ITA_RST_CLOCK_STOP;
    end else begin
      clock_stop_q <= clock_stop_d;
    end
  end

  // Direct subclock select bit
  always_ff @(posedge clk) begin
    if (rst) begin
      direct_sub_q <= ITA_RST_SUB_OUT_SEL[ITA_DIRECT_BIT];
    end else begin
      direct_sub_q <= direct_sub_d;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Counter register
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_count_q <= ITA_RST_TIMER_COUNT;
    end else begin
      timer_count_q <= timer_count_d;
    end
  end

  // System prescaler register
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_pre_q <= '0;
    end else begin
      sys_pre_q <= sys_pre_d;
    end
  end

  // Subclock prescaler register
  always_ff @(posedge clk) begin
    if (rst) begin
      sub_pre_q <= '0;
    end else begin
      sub_pre_q <= sub_pre_d;
    end
  end

  // Subclock sample register
  always_ff @(posedge clk) begin
    if (rst) begin
      sub_prev_q <= 1'b0;
    end else begin
      sub_prev_q <= sub_prev_d;
    end
  end

  // Overflow pulse register, one cycle per wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // Pin level, held low in reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  // Pin enable, held low in reset
  // Enable and level share one stage so they never disagree
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_oe_q <= 1'b0;
    end else begin
      pin_oe_q <= pin_oe_d;
    end
  end

  assign rdata               = rdata_q;
  assign clock_output_pin    = pin_q;
  assign clock_output_pin_oe = pin_oe_q;
  assign overflow_request    = ovf_q;
  assign timer_count         = timer_count_q;

endmodule // ita_timer

// ==== verification/ita_timer_sva.sv ====
module ita_timer_sva #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              rd,
  input wire logic [7:0]        rdata,
  input wire logic              port_mode_one_oe,
  input wire logic              clock_output_pin,
  input wire logic              clock_output_pin_oe,
  input wire logic              overflow_request,
  input wire logic [7:0]        timer_count
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read path and register contents
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  a_fixed_bit: assert property ($past(rd) && $past(addr) == 16'hFFB0 |-> rdata[4])
    else $error("mode bit 4 not one");
  a_rsvd_ones: assert property ($past(rd) && $past(addr) == 16'hFF92 |-> &rdata[7:1])
    else $error("select reserved bits not one");
  a_count_read: assert property ($past(rd) && $past(addr) == 16'hFFB1
    |-> rdata == $past(timer_count)) else $error("count read wrong");
  // Counter steps, wrap and overflow pulse
  a_count_step: assert property ($changed(timer_count)
    |-> timer_count == 8'($past(timer_count) + 1) || timer_count == 8'h00)
    else $error("counter jumped");
  a_wrap_flag: assert property ($past(timer_count) == 8'hFF && timer_count == 8'h00
    |-> ##[0:1] overflow_request) else $error("no overflow at wrap");
  a_flag_zero: assert property (overflow_request |-> timer_count == 8'h00)
    else $error("overflow without wrap");
  // Clock pin gating
  a_oe_copy: assert property (!$past(rst) && !$past(rst, 2)
    |-> clock_output_pin_oe == $past(port_mode_one_oe)) else $error("pin enable wrong");
  a_pin_gated: assert property (!clock_output_pin_oe |-> !clock_output_pin)
    else $error("pin driven while disabled");
  c_overflow: cover property (overflow_request);
  c_wrap: cover property ($past(timer_count) == 8'hFF && timer_count == 8'h00);
  c_pin: cover property ($rose(clock_output_pin));
endmodule // ita_timer_sva

// ==== verification/ita_timer_bench.sv ====
module ita_timer_bench import ita_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, sub_clk = 0, oe = 0, pin, pin_oe, ovf, p;
  logic [15:0] addr = 0;
  logic [7:0]  wdata = 0, rdata, cnt;
  logic [1:0]  mode = 0;
  int          failures = 0, cmp_count = 0, cyc = 0;
  ita_timer dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .sub_clk, .op_mode(mode),
    .port_mode_one_oe(oe), .clock_output_pin(pin), .clock_output_pin_oe(pin_oe),
    .overflow_request(ovf), .timer_count(cnt));
  // Clocks: system 20 ns, subclock 16 system cycles
  initial forever #10 clk = ~clk;
  initial forever #160 sub_clk = ~sub_clk;
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      summarize;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e, "read");
  endtask
  // Cycles until the counter next moves
  task automatic gap(output int n);
    logic [7:0] v;
    v = cnt;
    n = 0;
    while (cnt === v) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Rising edges of the clock pin over a window
  task automatic edges(input int ncyc, input int exp);
    int e;
    e = 0;
    repeat (ncyc) begin
      @(negedge clk);
      e += int'(pin === 1'b1 && p === 1'b0);
      p = pin;
    end
    chk(16'(e > exp + 1 || e + 1 < exp), 16'h0, "pin edges");
  endtask
  task automatic t_regs;
    rchk(16'hFFB0, 8'h10);
    rchk(16'hFFB1, 8'h00);
    rchk(16'hFFFA, 8'hFF);
    rchk(16'hFF92, 8'hFE);
    rchk(16'h1234, 8'h00);
    wreg(16'hFFB0, 8'hEC);
    rchk(16'hFFB0, 8'hFC);
    wreg(16'hFFB1, 8'h55);
    rchk(16'hFFB1, 8'h00);
    $display("registers done");
  endtask
  task automatic t_ticks;
    int n;
    int div[12] = '{8192, 4096, 2048, 512, 256, 128, 32, 8, 2048, 1024, 512, 64};
    logic [7:0] v;
    for (int c = 0; c < 12; c++) begin
      wreg(16'hFFB0, 8'(c));
      gap(n);
      gap(n);
      chk(16'(n), 16'(div[c]), "tick gap");
    end
    repeat (200) @(negedge clk);
    wreg(16'hFFB0, 8'h0C);
    repeat (200) @(negedge clk);
    chk(cnt, 8'h00, "clear");
    wreg(16'hFFB0, 8'h07);
    while (cnt !== 8'hFF) @(negedge clk);
    while (cnt === 8'hFF) @(negedge clk);
    chk(cnt, 8'h00, "wrap");
    chk(ovf, 1'b1, "overflow");
    @(negedge clk);
    chk(ovf, 1'b0, "overflow pulse");
    wreg(16'hFFFA, 8'hFE);
    v = cnt;
    n = 0;
    repeat (300) begin
      @(negedge clk);
      n += int'(ovf === 1'b1);
    end
    chk(cnt, v, "standby hold");
    chk(16'(n), 16'h0, "standby overflow");
    $display("counting done");
  endtask
  task automatic t_pin;
    oe <= 1;
    for (int s = 0; s < 8; s++) begin
      for (int m = 0; m < 4; m++) begin
        wreg(16'hFFB0, 8'(s << 5));
        mode <= 2'(m);
        edges(s < 4 ? 64 : 1024, (s < 4 ? m < 2 : m < 3) ? 64 / (32 >> (s % 4)) : 0);
      end
    end
    wreg(16'hFF92, 8'h01);
    edges(1024, 64);
    oe <= 0;
    edges(64, 0);
    $display("clock pin done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_regs;
    t_ticks;
    t_pin;
    summarize;
  end
endmodule // ita_timer_bench
bind ita_timer ita_timer_sva #(.ADDR_W(ADDR_W)) u_sva (.clk, .rst, .addr, .rd, .rdata,
  .port_mode_one_oe, .clock_output_pin, .clock_output_pin_oe, .overflow_request, .timer_count);
